// ==== design/supply_monitor_pkg.sv ====
// supply monitor package: register map, field layout, timing constants, carriers
// assumes a 20 MHz system clock and an 8-bit register behind a classic wishbone slave
//
// Overview of operation
// - monitoring and flag only while enabled
// - four selectable trip levels, 2.63 to 4.37 V
// - flag set while comparator status low
// - hold-off counter runs while flag set and comparator stays high
// - flag cleared when hold-off counter expires
// - software may also write the flag
// - software clear ignored while comparator low
// - status bit 6 read-only, live comparator
// - status reads 1 above trip, 0 below
// - flag interrupt only when irq_enable_priority_two_i set; unmasked status events interrupt regardless
// - short comparator glitches are filtered out
// - trip select bits 4:3, 00 highest
// - bit 0 enables or disables the monitor
package supply_monitor_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_INDEX      = 8'hdf;
    localparam logic [9:0] CTRL_BYTE_ADDR  = {CTRL_INDEX, 2'b00};
    localparam logic [9:0] IRQ_STATUS_ADDR = 10'h3e0;
    localparam logic [9:0] IRQ_MASK_ADDR   = 10'h3e4;
    localparam logic [7:0] CTRL_RESET      = 8'hde;

    localparam int ENABLE_BIT  = 0;
    localparam int TRIP_LSB    = 3;
    localparam int TRIP_MSB    = 4;
    localparam int FLAG_BIT    = 5;
    localparam int STATUS_BIT  = 6;

    // interrupt status/mask layout
    localparam int EV_FLAG_SET  = 0;
    localparam int EV_FLAG_CLR  = 1;
    localparam int EV_WIDTH     = 2;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam longint CLK_HZ        = 20000000;
    localparam longint HOLDOFF_MS    = 250;
    localparam longint HOLDOFF_CYC   = (HOLDOFF_MS * CLK_HZ) / 1000;
    localparam int     HOLD_W        = 23;
    localparam int     FILTER_CYC    = 4;
    localparam int     FILTER_W      = 3;

    // ----------------------------------------------------------------
    // trip levels in millivolts
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        TRIP_4370 = 2'b00,
        TRIP_3080 = 2'b01,
        TRIP_2930 = 2'b10,
        TRIP_2630 = 2'b11
    } trip_sel_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [9:0]  adr;
        logic [31:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } wb_rsp_t;

endpackage : supply_monitor_pkg

// ==== design/glitch_filter.sv ====
// glitch filter: a level must hold a fixed count of cycles before it is passed on
// assumes the input is already synchronised to clk_i
`timescale 1ns/1ps
module glitch_filter
    import supply_monitor_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic ce_i,
    input  wire logic raw_i,
    output logic      level_o
);
    typedef struct packed {
        logic                level;
        logic [FILTER_W-1:0] cnt;
    } filt_state_t;

    filt_state_t s_q;
    filt_state_t s_d;

    // ----------------------------------------------------------------
    // qualify transitions
    // ----------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        if (raw_i == s_q.level) begin
            s_d.cnt = '0;
        end else if (s_q.cnt == FILTER_W'(FILTER_CYC - 1)) begin
            s_d.level = raw_i;
            s_d.cnt   = '0;
        end else begin
            s_d.cnt = s_q.cnt + FILTER_W'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '{level: 1'b1, cnt: '0};
        end else if (ce_i) begin
            s_q <= s_d;
        end
    end

    assign level_o = s_q.level;
endmodule : glitch_filter

// ==== design/sync2.sv ====
// two-flop synchroniser for a level from outside the clock domain
// assumes a slowly changing asynchronous input
`timescale 1ns/1ps
module sync2 (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic ce_i,
    input  wire logic async_i,
    output logic      sync_o
);
    logic [1:0] s_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= 2'b11;
        end else if (ce_i) begin
            s_q <= {s_q[0], async_i};
        end
    end

    assign sync_o = s_q[1];
endmodule : sync2

// ==== design/supply_monitor_flag_logic.sv ====
// supply monitor flag logic: control register, hold-off timer, wishbone slave
// assumes an analog comparator input and a core that takes a level interrupt
`timescale 1ns/1ps
module supply_monitor_flag_logic
    import supply_monitor_pkg::*;
#(
    parameter logic [HOLD_W-1:0] HOLDOFF_CYCLES = HOLD_W'(HOLDOFF_CYC)
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [9:0]  adr_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    input  wire logic        supply_above_i,
    input  wire logic        irq_enable_priority_two_i,
    output logic [1:0]       trip_level_select_o,
    output logic             comparator_enable_o,
    output logic             irq_o
);
    typedef struct packed {
        logic                monitor_enable_bit;
        logic [1:0]          trip_level_select;
        logic                low_supply_irq_flag;
        logic [1:0]          reserved_hi;
        logic [1:0]          reserved_lo;
        logic [HOLD_W-1:0]   hold_cnt;
        logic [EV_WIDTH-1:0] irq_status;
        logic [EV_WIDTH-1:0] irq_mask;
        logic                ack;
        logic [31:0]         rdata;
    } mon_state_t;

    mon_state_t s_q;
    mon_state_t s_d;
    wb_req_t    req;
    logic       cmp_sync;
    logic       supply_compare_status;
    logic       access;
    logic       wr_lane0;
    logic [7:0] ctrl_view;

    assign req = '{cyc: cyc_i, stb: stb_i, we: we_i, sel: sel_i, adr: adr_i, dat: dat_i};

    // ----------------------------------------------------------------
    // comparator path
    // ----------------------------------------------------------------
    sync2 u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .async_i (supply_above_i),
        .sync_o  (cmp_sync)
    );

    glitch_filter u_filter (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .raw_i   (cmp_sync),
        .level_o (supply_compare_status)
    );

    assign access   = req.cyc && req.stb && !s_q.ack;
    assign wr_lane0 = access && req.we && req.sel[0];

    always_comb begin
        ctrl_view                     = {s_q.reserved_hi[1], 1'b0, s_q.low_supply_irq_flag,
                                         s_q.trip_level_select, s_q.reserved_lo,
                                         s_q.monitor_enable_bit};
        ctrl_view[STATUS_BIT]         = supply_compare_status;
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic flag_set;
        logic flag_clr;
        logic was_flag;
        flag_set = 1'b0;
        flag_clr = 1'b0;
        was_flag = s_q.low_supply_irq_flag;
        s_d      = s_q;
        s_d.ack  = access;

        // register writes
        if (wr_lane0 && req.adr == CTRL_BYTE_ADDR) begin
            s_d.monitor_enable_bit  = req.dat[ENABLE_BIT];
            s_d.trip_level_select   = req.dat[TRIP_MSB:TRIP_LSB];
            s_d.low_supply_irq_flag = req.dat[FLAG_BIT];
        end
        if (wr_lane0 && req.adr == IRQ_MASK_ADDR) begin
            s_d.irq_mask = req.dat[EV_WIDTH-1:0];
        end

        // hardware flag behaviour
        if (!s_q.monitor_enable_bit) begin
            s_d.hold_cnt = '0;
        end else if (!supply_compare_status) begin
            s_d.low_supply_irq_flag = 1'b1;
            s_d.hold_cnt            = '0;
        end else if (s_q.low_supply_irq_flag) begin
            if (s_q.hold_cnt >= HOLDOFF_CYCLES - HOLD_W'(1)) begin
                s_d.low_supply_irq_flag = 1'b0;
                s_d.hold_cnt            = '0;
            end else begin
                s_d.hold_cnt = s_q.hold_cnt + HOLD_W'(1);
            end
        end else begin
            s_d.hold_cnt = '0;
        end

        // event capture: set wins over write-one-to-clear
        flag_set = !was_flag && s_d.low_supply_irq_flag;
        flag_clr = was_flag && !s_d.low_supply_irq_flag;
        if (wr_lane0 && req.adr == IRQ_STATUS_ADDR) begin
            s_d.irq_status = s_q.irq_status & ~req.dat[EV_WIDTH-1:0];
        end
        if (flag_set) begin
            s_d.irq_status[EV_FLAG_SET] = 1'b1;
        end
        if (flag_clr) begin
            s_d.irq_status[EV_FLAG_CLR] = 1'b1;
        end

        // read data
        s_d.rdata = '0;
        if (access && !req.we) begin
            unique case (req.adr)
                CTRL_BYTE_ADDR:  s_d.rdata = {24'h000000, ctrl_view};
                IRQ_STATUS_ADDR: s_d.rdata = {30'h0, s_q.irq_status};
                IRQ_MASK_ADDR:   s_d.rdata = {30'h0, s_q.irq_mask};
                default:         s_d.rdata = '0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q.monitor_enable_bit  <= CTRL_RESET[ENABLE_BIT];
            s_q.trip_level_select   <= CTRL_RESET[TRIP_MSB:TRIP_LSB];
            s_q.low_supply_irq_flag <= CTRL_RESET[FLAG_BIT];
            s_q.reserved_hi         <= CTRL_RESET[7:6];
            s_q.reserved_lo         <= CTRL_RESET[2:1];
            s_q.hold_cnt            <= '0;
            s_q.irq_status          <= '0;
            s_q.irq_mask            <= '0;
            s_q.ack                 <= 1'b0;
            s_q.rdata               <= '0;
        end else if (ce_i) begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign dat_o               = s_q.rdata;
    assign ack_o               = s_q.ack;
    assign trip_level_select_o = s_q.trip_level_select;
    assign comparator_enable_o = s_q.monitor_enable_bit;
    assign irq_o = (irq_enable_priority_two_i && s_q.low_supply_irq_flag)
                   || |(s_q.irq_status & s_q.irq_mask);
endmodule : supply_monitor_flag_logic

// ==== tb/supply_monitor_flag_logic_props.sv ====
// checker on the ports of the supply monitor flag logic
// assumes one clock domain; bound from the bench
`timescale 1ns/1ps
module supply_monitor_flag_logic_props
    import supply_monitor_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        ce_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [9:0]  adr_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic        supply_above_i,
    input wire logic [1:0]  trip_level_select_o,
    input wire logic        comparator_enable_o
);
    logic [3:0] lo_q;
    logic [3:0] hi_q;
    logic       rd_q;
    logic       wc;
    assign wc = we_i && adr_i == CTRL_BYTE_ADDR;
    // counts enabled cycles of a steady comparator level
    always_ff @(posedge clk_i) begin
        rd_q <= !rst_i && ce_i && cyc_i && stb_i && !ack_o && !we_i && adr_i == CTRL_BYTE_ADDR;
        lo_q <= (rst_i || !comparator_enable_o || supply_above_i) ? 4'h0 : lo_q + 4'(lo_q != 4'hf);
        hi_q <= (rst_i || !comparator_enable_o || !supply_above_i) ? 4'h0 : hi_q + 4'(hi_q != 4'hf);
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ack_pulse_a: assert property (ack_o && ce_i |=> !ack_o)
        else $error("ack too long");
    ack_resp_a: assert property (cyc_i && stb_i && !ack_o && ce_i |=> ack_o)
        else $error("no ack");
    quiet_data_a: assert property (ack_o && $past(we_i || (adr_i != CTRL_BYTE_ADDR
        && adr_i != IRQ_STATUS_ADDR && adr_i != IRQ_MASK_ADDR)) |-> dat_o == 32'h0)
        else $error("data not zero");
    ctrl_fields_a: assert property (ack_o && rd_q |-> dat_o[31:8] == 24'h0 && dat_o[7]
        && dat_o[2:1] == 2'h3 && dat_o[4:3] == trip_level_select_o
        && dat_o[0] == comparator_enable_o) else $error("bad control read");
    low_flag_a: assert property (ack_o && rd_q && lo_q > 4'hb
        |-> dat_o[FLAG_BIT] && !dat_o[STATUS_BIT]) else $error("flag not set");
    high_status_a: assert property (ack_o && rd_q && hi_q > 4'hb
        |-> dat_o[STATUS_BIT]) else $error("status not high");
    trip_write_a: assert property ($changed(trip_level_select_o)
        |-> $past(wc) || $past(wc, 2)) else $error("trip changed alone");
    enable_write_a: assert property ($changed(comparator_enable_o)
        |-> $past(wc) || $past(wc, 2)) else $error("enable changed alone");
endmodule : supply_monitor_flag_logic_props

// ==== tb/supply_comparator_model.sv ====
// analog comparator model: supply in millivolts against the trip level
// assumes the bench sets the supply level
`timescale 1ns/1ps
module supply_comparator_model (
    input  wire logic [1:0]  trip_i,
    input  wire logic [15:0] vdd_mv_i,
    output logic             above_o
);
    logic [15:0] thr;
    always_comb begin
        case (trip_i)
            2'h0:    thr = 16'h1112;
            2'h1:    thr = 16'h0c08;
            2'h2:    thr = 16'h0b72;
            default: thr = 16'h0a46;
        endcase
        above_o = vdd_mv_i > thr;
    end
endmodule : supply_comparator_model

// ==== tb/supply_monitor_flag_logic_test.sv ====
// self-checking bench for the supply monitor flag logic
// assumes the comparator model and the port checker
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module supply_monitor_flag_logic_test import supply_monitor_pkg::*;;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0;
    logic        we = 1'b0;
    logic        irq_en = 1'b0;
    logic        ce = 1'b1;
    logic [9:0]  adr = 10'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] dat_o;
    logic [31:0] r;
    logic [15:0] vdd = 16'h1388;
    logic [15:0] thr [4] = '{16'h1112, 16'h0c08, 16'h0b72, 16'h0a46};
    logic        ack_o, above, en_o, irq_o;
    logic [1:0]  trip_o;
    int          n_fail = 0;
    int          compares = 0;
    always #25 clk_i = ~clk_i;
    supply_monitor_flag_logic #(.HOLDOFF_CYCLES(23'h14)) supply_monitor_flag_logic_i (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .cyc_i(cyc), .stb_i(cyc), .we_i(we),
        .sel_i(4'h1), .adr_i(adr), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o),
        .supply_above_i(above), .irq_enable_priority_two_i(irq_en),
        .trip_level_select_o(trip_o), .comparator_enable_o(en_o), .irq_o(irq_o));
    supply_comparator_model supply_comparator_model_i (
        .trip_i(trip_o), .vdd_mv_i(vdd), .above_o(above));
    task automatic end_of_test();
        if (n_fail == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_of_test
    task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        // ack and read data are taken at the rising edge, before the design updates them
        do begin
            @(posedge clk_i);
            k++;
        end while (ack_o !== 1'b1 && k < 20);
        r = dat_o;
        cyc <= 1'b0;
        if (ack_o !== 1'b1) begin
            n_fail++;
            end_of_test();
        end
    endtask : wb
    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask : idle
    task automatic ck_irq(input logic e);
        @(negedge clk_i);
        `CHK(irq_o, e)
    endtask : ck_irq
    task automatic t_regs();
        wb(1'b0, CTRL_BYTE_ADDR, 8'h0);
        `CHK(r[7:0], CTRL_RESET)
        wb(1'b0, 10'h100, 8'h0);
        `CHK(r, 32'h0)
        wb(1'b1, CTRL_BYTE_ADDR, 8'h00);
        wb(1'b0, CTRL_BYTE_ADDR, 8'h0);
        `CHK(r[7:0], 8'hc6)
        // clock enable low freezes the comparator path
        vdd <= 16'h0fa0;
        ce  <= 1'b0;
        idle(12);
        ce  <= 1'b1;
        wb(1'b0, CTRL_BYTE_ADDR, 8'h0);
        `CHK(r[6], 1'b1)
        idle(12);
        wb(1'b0, CTRL_BYTE_ADDR, 8'h0);
        `CHK(r[6], 1'b0)
        vdd <= 16'h1388;
        idle(12);
    endtask : t_regs
    task automatic t_trip();
        for (int i = 0; i < 4; i++) begin
            wb(1'b1, CTRL_BYTE_ADDR, 8'h01 | 8'(i << 3));
            `CHK(trip_o, 2'(i))
            vdd <= thr[i] + 16'h000a;
            idle(12);
            wb(1'b0, CTRL_BYTE_ADDR, 8'h0);
            `CHK(r[6], 1'b1)
            vdd <= thr[i] - 16'h000a;
            idle(12);
            wb(1'b0, CTRL_BYTE_ADDR, 8'h0);
            `CHK(r[6], 1'b0)
        end
    endtask : t_trip
    task automatic t_hold();
        wb(1'b1, CTRL_BYTE_ADDR, 8'h19);
        wb(1'b0, CTRL_BYTE_ADDR, 8'h0);
        `CHK(r[5], 1'b1)
        vdd <= 16'h0ce4;
        idle(14);
        vdd <= 16'h07d0;
        idle(10);
        vdd <= 16'h0ce4;
        idle(16);
        wb(1'b0, CTRL_BYTE_ADDR, 8'h0);
        `CHK(r[5], 1'b1)
        idle(30);
        wb(1'b0, CTRL_BYTE_ADDR, 8'h0);
        `CHK(r[5], 1'b0)
        vdd <= 16'h07d0;
        idle(2);
        vdd <= 16'h0ce4;
        idle(12);
        wb(1'b0, CTRL_BYTE_ADDR, 8'h0);
        `CHK(r[6:5], 2'h2)
        wb(1'b1, CTRL_BYTE_ADDR, 8'h39);
        wb(1'b0, CTRL_BYTE_ADDR, 8'h0);
        `CHK(r[5], 1'b1)
        wb(1'b1, CTRL_BYTE_ADDR, 8'h19);
        wb(1'b0, CTRL_BYTE_ADDR, 8'h0);
        `CHK(r[5], 1'b0)
    endtask : t_hold
    task automatic t_irq();
        wb(1'b1, IRQ_MASK_ADDR, 8'h0);
        wb(1'b1, IRQ_STATUS_ADDR, 8'h3);
        vdd <= 16'h07d0;
        idle(12);
        wb(1'b0, IRQ_STATUS_ADDR, 8'h0);
        `CHK(r, 32'h1)
        ck_irq(1'b0);
        idle(1);
        irq_en <= 1'b1;
        ck_irq(1'b1);
        idle(1);
        irq_en <= 1'b0;
        vdd <= 16'h0ce4;
        wb(1'b1, IRQ_MASK_ADDR, 8'h1);
        ck_irq(1'b1);
        idle(8);
        wb(1'b1, IRQ_STATUS_ADDR, 8'h1);
        ck_irq(1'b0);
        wb(1'b0, IRQ_MASK_ADDR, 8'h0);
        `CHK(r, 32'h1)
        idle(30);
        wb(1'b0, IRQ_STATUS_ADDR, 8'h0);
        `CHK(r, 32'h2)
        wb(1'b1, CTRL_BYTE_ADDR, 8'h18);
        `CHK(en_o, 1'b0)
        vdd <= 16'h07d0;
        idle(12);
        wb(1'b0, CTRL_BYTE_ADDR, 8'h0);
        `CHK(r[5], 1'b0)
    endtask : t_irq
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_trip();
        t_hold();
        t_irq();
        end_of_test();
    end
endmodule : supply_monitor_flag_logic_test
bind supply_monitor_flag_logic supply_monitor_flag_logic_props supply_monitor_flag_logic_props_i (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .supply_above_i(supply_above_i),
    .trip_level_select_o(trip_level_select_o), .comparator_enable_o(comparator_enable_o));
